/* File: rtl/ext_bus_defs.vh */
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH
`define RESET_FETCH_ADDR 24'hff2080
`define CS0_RESET_BASE 24'hff2000
`define CS0_RESET_LIMIT 24'hff20ff
`define EA_REGION_BASE 24'hff2000
`define EA_REGION_LIMIT 24'hff2fff
`define CHIP_CONFIG_ZERO_BHE_SEL_BIT 2
`define WSR_HOLD_EN_BIT 7
`define NUM_CS 6
`define CS_DEFAULT_IDX 5
`define ALE_CYCLES 4'h1
`define ADDR_PHASE_CYCLES 4'h2
`define DATA_PHASE_CYCLES 4'h2
`endif

/* File: rtl/ext_bus_pins.v */
`timescale 1ns/1ps
`include "ext_bus_defs.vh"
module ext_bus_pins (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_req,
  input wire i_req_write,
  input wire [23:0] i_req_addr,
  input wire i_req_word,
  input wire [15:0] i_req_wdata,
  input wire [15:0] i_int_bus,
  input wire i_bus16,
  input wire i_muxed,
  input wire [3:0] i_wait_states,
  input wire [7:0] i_chip_config_zero,
  input wire [7:0] i_window_select_reg,
  input wire i_hold_pin_special,
  input wire [143:0] i_cs_ranges,
  input wire [5:0] i_cs_ranges_valid,
  input wire [5:0] i_cs_bus16,
  input wire [5:0] i_cs_muxed,
  input wire [15:0] i_addr_data_lanes,
  input wire [15:0] i_port_lanes_out,
  input wire [15:0] i_port_lanes_oe_n,
  input wire [3:0] i_extended_addr_port,
  input wire i_external_access_n,
  input wire i_ready,
  input wire i_hold_n,
  output reg o_ack,
  output reg o_ack_internal,
  output reg [15:0] o_rdata,
  output reg [15:0] o_addr_low_lines,
  output reg [3:0] o_addr_upper_lines,
  output reg [15:0] o_addr_data_lanes,
  output reg [15:0] o_addr_data_lanes_oe_n,
  output reg o_ale,
  output reg o_rd_n,
  output reg o_wr_n,
  output reg o_byte_high_enable_n,
  output reg [5:0] o_chip_select_n,
  output reg o_bus_request_n,
  output reg o_hold_ack_n,
  output reg o_half_rate_clock_out
);
  localparam ST_IDLE = 3'h0;
  localparam ST_ADDR = 3'h1;
  localparam ST_DATA = 3'h2;
  localparam ST_WAIT = 3'h3;
  localparam ST_HOLD = 3'h4;
  localparam ST_END = 3'h5;

  // Range table: base[23:12] and limit[23:12] per chip select, 24 bits each
  function in_range;
    input [23:0] a;
    input [23:0] lo;
    input [23:0] hi;
    begin
      in_range = (a >= lo) && (a <= hi);
    end
  endfunction

  // Byte-high enable from access width and address bit 0
  function byte_high_n;
    input word;
    input a0;
    begin
      byte_high_n = !(word || a0);
    end
  endfunction

  // Write-high strobe: every write on a narrow bus, word or odd byte on a wide one
  function write_high_n;
    input write;
    input b16;
    input word;
    input a0;
    begin
      write_high_n = !(write && (!b16 || word || a0));
    end
  endfunction

  // Lane drivers at cycle start; a demux read releases only the data lanes
  function [15:0] start_oe_n;
    input muxed;
    input bus16;
    input write;
    begin
      if (muxed || write)
        start_oe_n = 16'h0000;
      else if (bus16)
        start_oe_n = 16'hffff;
      else
        start_oe_n = 16'h00ff;
    end
  endfunction

  reg [2:0] state_r;
  reg [2:0] state_nxt;
  reg [3:0] cnt_r;
  reg [23:0] addr_r;
  reg write_r;
  reg word_r;
  reg [15:0] wdata_r;
  reg bus16_r;
  reg muxed_r;
  reg [5:0] cs_hit_r;
  reg cs_boot_r;
  reg pend_r;
  reg [2:0] i;
  reg [5:0] hit;
  reg cs_bus16;
  reg cs_muxed;
  wire is_external;
  wire hold_en;
  wire hold_pending;

  // Live pin, no latch, so the region can be switched at run time
  assign is_external = !(in_range(i_req_addr, `EA_REGION_BASE, `EA_REGION_LIMIT) && i_external_access_n);
  assign hold_en = i_hold_pin_special && i_window_select_reg[`WSR_HOLD_EN_BIT];
  // A cycle that turns up while the bus is granted away
  assign hold_pending = (state_r == ST_HOLD) && i_req && is_external;

  always @* begin
    hit = 6'h00;
    for (i = 3'h0; i < 3'h6; i = i + 3'h1) begin
      if (i_cs_ranges_valid[i] && in_range(i_req_addr, {i_cs_ranges[i*24 +: 12], 12'h000},
          {i_cs_ranges[i*24+12 +: 12], 12'hfff}))
        hit[i] = 1'b1;
    end
    // Boot range stays on select 0 until software programs it
    if (cs_boot_r && in_range(i_req_addr, `CS0_RESET_BASE, `CS0_RESET_LIMIT))
      hit[0] = 1'b1;
    cs_bus16 = i_bus16;
    cs_muxed = i_muxed;
    if (hit == 6'h00) begin
      cs_bus16 = i_cs_bus16[`CS_DEFAULT_IDX];
      cs_muxed = i_cs_muxed[`CS_DEFAULT_IDX];
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (hold_en && !i_hold_n)
          state_nxt = ST_HOLD;
        else if (i_req && is_external)
          state_nxt = ST_ADDR;
      end
      ST_ADDR: if (cnt_r == 4'h1) state_nxt = ST_DATA;
      ST_DATA: if (cnt_r == 4'h1) state_nxt = ST_WAIT;
      ST_WAIT: if (cnt_r == 4'h0 && i_ready) state_nxt = ST_END;
      ST_HOLD: if (i_hold_n || !hold_en) state_nxt = ST_IDLE;
      ST_END: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      addr_r <= `RESET_FETCH_ADDR;
      write_r <= 1'b0;
      word_r <= 1'b0;
      wdata_r <= 16'h0000;
      bus16_r <= 1'b1;
      muxed_r <= 1'b1;
      cs_hit_r <= 6'h00;
      cs_boot_r <= 1'b1;
      pend_r <= 1'b0;
      o_ack <= 1'b0;
      o_ack_internal <= 1'b0;
      o_rdata <= 16'h0000;
      o_addr_low_lines <= 16'h0000;
      o_addr_upper_lines <= 4'h0;
      o_addr_data_lanes <= 16'h0000;
      o_addr_data_lanes_oe_n <= 16'hffff;
      o_ale <= 1'b0;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_byte_high_enable_n <= 1'b1;
      o_chip_select_n <= 6'h3f;
      o_bus_request_n <= 1'b1;
      o_hold_ack_n <= 1'b1;
      o_half_rate_clock_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      o_half_rate_clock_out <= ~o_half_rate_clock_out;
      o_ack <= 1'b0;
      o_ack_internal <= 1'b0;
      o_ale <= 1'b0;
      if (i_cs_ranges_valid[0])
        cs_boot_r <= 1'b0;
      if (state_r == ST_IDLE && state_nxt == ST_IDLE && i_req && !is_external)
        o_ack_internal <= 1'b1;
      if (state_r == ST_IDLE && state_nxt == ST_ADDR) begin
        addr_r <= i_req_addr;
        write_r <= i_req_write;
        word_r <= i_req_word;
        wdata_r <= i_req_wdata;
        bus16_r <= cs_bus16;
        muxed_r <= cs_muxed;
        cs_hit_r <= hit;
        cnt_r <= `ADDR_PHASE_CYCLES;
        o_ale <= 1'b1;
        o_addr_low_lines <= i_req_addr[15:0];
        o_addr_upper_lines <= i_req_addr[19:16];
        o_chip_select_n <= ~hit;
        if (cs_bus16) begin
          // Shared pin: enable from address bit 0 and width, or write-high strobe
          if (i_chip_config_zero[`CHIP_CONFIG_ZERO_BHE_SEL_BIT])
            o_byte_high_enable_n <= byte_high_n(i_req_word, i_req_addr[0]);
          else
            o_byte_high_enable_n <= 1'b1;
        end else begin
          o_byte_high_enable_n <= 1'b1;
        end
        o_addr_data_lanes_oe_n <= start_oe_n(cs_muxed, cs_bus16, i_req_write);
        if (!cs_muxed)
          o_addr_data_lanes <= i_req_write ? i_req_wdata : 16'h0000;
        else
          o_addr_data_lanes <= i_req_addr[15:0];
        if (!cs_muxed && !cs_bus16)
          o_addr_data_lanes[15:8] <= i_int_bus[15:8];
        if (!cs_muxed) begin
          o_rd_n <= i_req_write;
          o_wr_n <= !i_req_write;
        end
      end else if (state_r == ST_ADDR) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1) begin
          cnt_r <= `DATA_PHASE_CYCLES;
          if (muxed_r) begin
            // Second half of a muxed cycle: lanes switch from address to data; an 8-bit bus switches only lanes 7:0
            o_rd_n <= write_r;
            o_wr_n <= !write_r;
            if (bus16_r) begin
              o_addr_data_lanes <= wdata_r;
              o_addr_data_lanes_oe_n <= write_r ? 16'h0000 : 16'hffff;
            end else begin
              o_addr_data_lanes[7:0] <= wdata_r[7:0];
              o_addr_data_lanes_oe_n[7:0] <= write_r ? 8'h00 : 8'hff;
            end
            if (!i_chip_config_zero[`CHIP_CONFIG_ZERO_BHE_SEL_BIT])
              o_byte_high_enable_n <= write_high_n(write_r, bus16_r, word_r, addr_r[0]);
          end else if (!i_chip_config_zero[`CHIP_CONFIG_ZERO_BHE_SEL_BIT]) begin
            o_byte_high_enable_n <= write_high_n(write_r, bus16_r, word_r, addr_r[0]);
          end
        end
      end else if (state_r == ST_DATA) begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'h1)
          cnt_r <= i_wait_states;
      end else if (state_r == ST_WAIT) begin
        if (cnt_r != 4'h0)
          cnt_r <= cnt_r - 4'h1;
        if (state_nxt == ST_END) begin
          o_rdata <= bus16_r ? i_addr_data_lanes : {8'h00, i_addr_data_lanes[7:0]};
          o_ack <= 1'b1;
          o_rd_n <= 1'b1;
          o_wr_n <= 1'b1;
          o_byte_high_enable_n <= 1'b1;
          o_chip_select_n <= 6'h3f;
        end
      end
      if (state_nxt == ST_IDLE || state_nxt == ST_HOLD) begin
        // Lanes fall back to the port; upper lines to the extended port
        o_addr_data_lanes <= i_port_lanes_out;
        o_addr_data_lanes_oe_n <= i_port_lanes_oe_n;
        o_addr_upper_lines <= i_extended_addr_port;
        o_chip_select_n <= 6'h3f;
        o_byte_high_enable_n <= 1'b1;
      end
      // Acknowledge once the state has left the bus
      o_hold_ack_n <= !(state_nxt == ST_HOLD);
      // Request is held until hold drops, even if the cycle is withdrawn
      if (state_nxt != ST_HOLD)
        pend_r <= 1'b0;
      else if (hold_pending)
        pend_r <= 1'b1;
      // Raised on the same edge that gives the bus back, so it never outlasts the grant
      if (state_nxt != ST_HOLD)
        o_bus_request_n <= 1'b1;
      else if (pend_r || hold_pending)
        o_bus_request_n <= 1'b0;
    end
  end
endmodule

/* File: tb/ext_bus_pins_chk.sv */
`timescale 1ns/1ps
module ext_bus_pins_chk (
  input wire i_clk_sys,
  input wire i_rst_n,
  input wire i_req,
  input wire i_hold_n,
  input wire [7:0] i_window_select_reg,
  input wire i_hold_pin_special,
  input wire o_ale,
  input wire o_rd_n,
  input wire o_wr_n,
  input wire [5:0] o_chip_select_n,
  input wire o_bus_request_n,
  input wire o_hold_ack_n,
  input wire o_half_rate_clock_out
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  chk_clk_half: assert property ($past(i_rst_n) |-> o_half_rate_clock_out != $past(o_half_rate_clock_out))
    else $error("clock out did not toggle");
  chk_ale_pulse: assert property (o_ale |=> !o_ale)
    else $error("latch strobe too long");
  chk_ale_cause: assert property (o_ale |-> $past(i_req))
    else $error("latch strobe without request");
  chk_strobe_after: assert property (o_ale |-> ##2 !(o_rd_n && o_wr_n))
    else $error("no strobe after latch");
  chk_hold_gate: assert property ($fell(o_hold_ack_n) |-> $past(i_window_select_reg[7] & i_hold_pin_special & ~i_hold_n))
    else $error("hold taken without cause");
  chk_hold_quiet: assert property (!o_hold_ack_n |-> &o_chip_select_n && o_rd_n && o_wr_n && !o_ale)
    else $error("bus active while granted");
  chk_bus_request_n_hold: assert property ($fell(o_bus_request_n) |-> !o_hold_ack_n)
    else $error("request outside hold");
  chk_bus_request_n_stay: assert property (!o_bus_request_n && !i_hold_n |=> !o_bus_request_n)
    else $error("request dropped early");
  cov_ale: cover property (o_ale);
  cov_hold: cover property ($fell(o_hold_ack_n));
  cov_bus_request_n: cover property ($fell(o_bus_request_n));
endmodule

/* File: tb/ext_mem_model.sv */
`timescale 1ns/1ps
module ext_mem_model (
  input wire i_clk_sys,
  input wire i_rd_n,
  input wire i_wr_n,
  input wire i_slow,
  output wire [15:0] o_lanes,
  output wire o_ready
);
  reg [15:0] last_r = 16'h0;
  reg [2:0] cnt_r = 3'h0;
  // Released lanes flip every cycle so a late sample never sees stale data
  assign o_lanes = !i_rd_n ? 16'hc3a5 : ~last_r;
  assign o_ready = !i_slow || cnt_r >= 3'h5;
  always @(posedge i_clk_sys) begin
    last_r <= o_lanes;
    cnt_r <= (i_rd_n && i_wr_n) ? 3'h0 : cnt_r + {2'h0, cnt_r != 3'h7};
  end
endmodule

/* File: tb/test_ext_bus_pins.sv */
`timescale 1ns/1ps
module test_ext_bus_pins;
  reg i_clk_sys = 1'b0;
  reg i_rst_n = 1'b0;
  reg req = 1'b0, wr = 1'b0, word = 1'b1, ea_n = 1'b1, hold_n = 1'b1, hsp = 1'b0, slow = 1'b0, seen;
  reg [23:0] addr = 24'h0;
  reg [7:0] window_select_reg = 8'h0;
  reg [5:0] cs_at;
  reg [15:0] alo_at, lanes_at, rd_at;
  reg [3:0] aup_at;
  reg [1:0] got;
  reg bhe_at;
  reg [15:0] wdata = 16'h1234, ibus = 16'h0;
  reg b16 = 1'b1, mux = 1'b1, wrh_at;
  reg [3:0] wst = 4'h0;
  reg [7:0] ccr = 8'h04, hi_at;
  reg [143:0] rng = 144'h0;
  reg [5:0] rngv = 6'h0, csb16 = 6'h3f, csmux = 6'h3f;
  wire [15:0] dlanes;
  wire ack, acki, ale, rd_n, wr_n, bhe_n, bus_request_n_n, hold_ack_n_n, ready;
  wire [15:0] rdata, loe, lanes;
  wire [3:0] aup;
  wire [5:0] cs_n;
  wire [15:0] alo;
  integer err_count = 0, n_compared = 0, cyc, fast;
  initial forever #2.5 i_clk_sys = ~i_clk_sys;
  // Chip select 0 stays on its reset range; select 1 is programmed late in the run
  ext_bus_pins dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(req), .i_req_write(wr), .i_req_addr(addr),
    .i_req_word(word), .i_req_wdata(wdata), .i_int_bus(ibus), .i_bus16(b16), .i_muxed(mux),
    .i_wait_states(wst), .i_chip_config_zero(ccr), .i_window_select_reg(window_select_reg), .i_hold_pin_special(hsp),
    .i_cs_ranges(rng), .i_cs_ranges_valid(rngv), .i_cs_bus16(csb16), .i_cs_muxed(csmux),
    .i_addr_data_lanes(lanes), .i_port_lanes_out(16'h0f0f), .i_port_lanes_oe_n(16'h00ff),
    .i_extended_addr_port(4'h9), .i_external_access_n(ea_n), .i_ready(ready), .i_hold_n(hold_n), .o_ack(ack),
    .o_ack_internal(acki), .o_rdata(rdata), .o_addr_low_lines(alo), .o_addr_upper_lines(aup),
    .o_addr_data_lanes(dlanes), .o_addr_data_lanes_oe_n(loe), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_byte_high_enable_n(bhe_n), .o_chip_select_n(cs_n), .o_bus_request_n(bus_request_n_n), .o_hold_ack_n(hold_ack_n_n),
    .o_half_rate_clock_out());
  ext_mem_model mem (.i_clk_sys(i_clk_sys), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_slow(slow), .o_lanes(lanes),
    .o_ready(ready));
  task chk(input [23:0] s, input [23:0] e);
    begin
      n_compared = n_compared + 1;
      if (s !== e) begin
        err_count = err_count + 1;
        $display("BAD %0t seen %h expected %h", $time, s, e);
      end
    end
  endtask
  task report_and_stop;
    begin
      $display("compared %0d mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
    end
  endtask
  task acc(input [23:0] a, input w);
    begin
      @(negedge i_clk_sys);
      addr = a;
      wr = w;
      req = 1'b1;
      cyc = 0;
      seen = 1'b0;
      wrh_at = 1'b1;
      hi_at = 8'h00;
      while (cyc < 40 && ack !== 1'b1 && acki !== 1'b1) begin
        @(posedge i_clk_sys);
        #1;
        cyc = cyc + 1;
        if (ale === 1'b1) begin
          seen = 1'b1;
          cs_at = cs_n;
          alo_at = alo;
          aup_at = aup;
          lanes_at = dlanes;
          bhe_at = bhe_n;
        end
        if (wr_n === 1'b0) begin
          wrh_at = bhe_n;
          hi_at = dlanes[15:8];
        end
      end
      got = {ack, acki};
      rd_at = rdata;
      if (cyc >= 40) begin
        err_count = err_count + 1;
        report_and_stop;
      end
      @(negedge i_clk_sys);
      req = 1'b0;
      @(negedge i_clk_sys);
    end
  endtask
  task t_int_then_ext;
    begin
      acc(24'hff2100, 1'b0);
      chk(got, 2'b01);
      chk(seen, 1'b0);
      ea_n = 1'b0;
      acc(24'hff2080, 1'b0);
      fast = cyc;
      chk(got, 2'b10);
      chk(cs_at, 6'h3e);
      chk(alo_at, 16'h2080);
      chk(aup_at, 4'hf);
      chk(lanes_at, 16'h2080);
      chk(bhe_at, 1'b0);
      chk(rd_at, 16'hc3a5);
      chk(loe, 16'h00ff);
    end
  endtask
  task t_nomatch_slow;
    begin
      ea_n = 1'b1;
      word = 1'b0;
      acc(24'h034560, 1'b0);
      chk(got, 2'b10);
      chk(cs_at, 6'h3f);
      chk(aup_at, 4'h3);
      chk(bhe_at, 1'b1);
      slow = 1'b1;
      acc(24'h034561, 1'b1);
      chk(cyc > fast, 1'b1);
      chk(bhe_at, 1'b0);
    end
  endtask
  task t_hold;
    begin
      window_select_reg = 8'h80;
      hsp = 1'b1;
      hold_n = 1'b0;
      fork
        acc(24'h034562, 1'b0);
        begin
          repeat (5) @(negedge i_clk_sys);
          chk(hold_ack_n_n, 1'b0);
          chk(bus_request_n_n, 1'b0);
          chk(cs_n, 6'h3f);
          hold_n = 1'b1;
        end
      join
      chk(got, 2'b10);
    end
  endtask
  task t_cs_modes;
    begin
      slow = 1'b0;
      rng = {96'h0, 12'h034, 12'h034, 24'h0};
      rngv = 6'h02;
      mux = 1'b0;
      wdata = 16'hbeef;
      acc(24'h034100, 1'b1);
      chk(cs_at, 6'h3d);
      chk(lanes_at, 16'hbeef);
      chk(aup, 4'h9);
      b16 = 1'b0;
      ibus = 16'h5a00;
      acc(24'h034102, 1'b0);
      chk(lanes_at[15:8], 8'h5a);
      chk(rd_at, 16'h00a5);
      mux = 1'b1;
      ccr = 8'h00;
      wst = 4'h3;
      acc(24'h034562, 1'b1);
      chk(wrh_at, 1'b0);
      chk(hi_at, 8'h45);
      chk(cyc, fast + 3);
    end
  endtask
  initial begin
    repeat (12) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    @(negedge i_clk_sys);
    t_int_then_ext;
    t_nomatch_slow;
    t_hold;
    t_cs_modes;
    report_and_stop;
  end
endmodule
bind ext_bus_pins ext_bus_pins_chk u_chk (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_req(i_req),
  .i_hold_n(i_hold_n), .i_window_select_reg(i_window_select_reg), .i_hold_pin_special(i_hold_pin_special),
  .o_ale(o_ale), .o_rd_n(o_rd_n), .o_wr_n(o_wr_n), .o_chip_select_n(o_chip_select_n),
  .o_bus_request_n(o_bus_request_n), .o_hold_ack_n(o_hold_ack_n), .o_half_rate_clock_out(o_half_rate_clock_out));
